// *** bench/sar_core_model.sv ***
// sar_core_model: behavioural sample-and-hold and sar core plus rc oscillator.
// assumes sample_hold is high while acquiring and conv_busy high while converting.
`timescale 1ns/100ps
`default_nettype none
module sar_core_model (
	input wire logic ref_clk,
	input wire logic sample_hold,
	input wire logic conv_busy,
	input wire logic [3:0] mux_channel,
	output logic [11:0] conv_result_pin,
	output logic rc_osc_pin
);
	logic [3:0] held_ch;
	initial begin
		held_ch = 4'h0;
		conv_result_pin = 12'h000;
		rc_osc_pin = 1'h0;
	end
	// result names the held input; outside a conversion the lines keep toggling
	always @(posedge ref_clk) begin
		if (sample_hold) held_ch <= mux_channel;
		conv_result_pin <= conv_busy ? {8'hA0, held_ch} : ~conv_result_pin;
	end
	// free running, unrelated in phase to ref_clk
	always #410 rc_osc_pin = ~rc_osc_pin;
endmodule // sar_core_model
`default_nettype wire

// *** bench/sar_seq_test.sv ***
// sar_seq_test: self-checking bench for the sar sequencer over apb.
// assumes sar_core_model stands on the analog side of the sequencer.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module sar_seq_test;
	import sar_pkg::*;
	localparam int P = 14;
	typedef struct packed { logic [1:0] f; logic [3:0] c; logic [31:0] x; } sar_row_t;
	sar_row_t rows [4] = '{'{2'h0, 4'h3, 32'h00000A03}, '{2'h1, 4'h5, 32'hFFFFFA05},
		'{2'h2, 4'h6, 32'h0000A060}, '{2'h3, 4'hC, 32'h0000A0C0}};
	logic [3:0] scan_ch [8] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h9, 4'hB, 4'hD};
	logic ref_clk, sys_rst, psel, penable, pwrite, timer_trig, ext_trig_pin, rc_osc_pin;
	logic pready, pslverr, sample_hold, conv_busy, conv_clk_tick, irq_flag, e;
	logic [31:0] paddr, pwdata, prdata, q;
	logic [3:0] mux_channel;
	logic [11:0] conv_result_pin;
	int num_errors, cmp_count, n, d, lt, sp;
	sar_seq dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_trig(timer_trig), .ext_trig_pin(ext_trig_pin),
		.rc_osc_pin(rc_osc_pin), .conv_result_pin(conv_result_pin), .sample_hold(sample_hold),
		.conv_busy(conv_busy), .conv_clk_tick(conv_clk_tick), .mux_channel(mux_channel),
		.irq_flag(irq_flag));
	sar_core_model core (.ref_clk(ref_clk), .sample_hold(sample_hold), .conv_busy(conv_busy),
		.mux_channel(mux_channel), .conv_result_pin(conv_result_pin), .rc_osc_pin(rc_osc_pin));
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {24'h000000, a};
		pwdata <= dt;
		@(posedge ref_clk);
		penable <= 1'h1;
		@(posedge ref_clk);
		while (pready !== 1'h1) @(posedge ref_clk);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dt);
		apb(1'h1, a, dt);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'h0, a, 32'h00000000);
	endtask
	// software leaves sequencing settings alone until the module is off
	task automatic off;
		wr(SAR_CTRL1_OFF, 32'h00000000);
		wr(SAR_STAT_OFF, 32'h00000000);
		wr(SAR_CTRL2_OFF, 32'h00000000);
	endtask
	task automatic wait_irq(output int cnt);
		int t;
		logic pb;
		cnt = 0;
		// irq_flag trails a flag clear by one cycle
		for (t = 0; t < 4 && irq_flag === 1'h1; t++) @(posedge ref_clk);
		pb = conv_busy;
		for (t = 0; t < 5000 && irq_flag !== 1'h1; t++) begin
			@(posedge ref_clk);
			if (pb === 1'h1 && conv_busy === 1'h0) cnt++;
			pb = conv_busy;
		end
	endtask
	task automatic start_sw(input logic [1:0] f, input logic [3:0] c);
		wr(SAR_CTRL3_OFF, 32'h0000000D);
		wr(SAR_INSEL_OFF, {24'h000000, 4'hF, c});
		wr(SAR_CTRL1_OFF, {24'h000000, f, 6'h01});
		wr(SAR_CTRL1_OFF, {24'h000000, f, 6'h03});
		repeat (20) @(posedge ref_clk);
		wr(SAR_CTRL1_OFF, {24'h000000, f, 6'h01});
	endtask
	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end
	initial begin
		#(50 * 60000);
		num_errors++;
		close_out;
	end
	initial begin
		{sys_rst, psel, penable, pwrite, timer_trig, ext_trig_pin} = 6'h20;
		paddr = 32'h00000000;
		pwdata = 32'h00000000;
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'h0;
		@(posedge ref_clk);
		for (int a = 0; a < 24; a += 4) begin
			rd(a[7:0]);
			`CHK("reset_val", 32'h00000000, q)
		end
		rd(8'h20);
		`CHK("unmapped_err", 1'h1, e)
		$display("reset test done");
		foreach (rows[i]) begin
			start_sw(rows[i].f, rows[i].c);
			for (n = 0; n < 40 && conv_busy !== 1'h1; n++) @(posedge ref_clk);
			d = 0;
			lt = 0;
			sp = 0;
			while (conv_busy === 1'h1 && d < 400) begin
				@(posedge ref_clk);
				d++;
				if (conv_clk_tick === 1'h1) begin
					sp = d - lt;
					lt = d;
				end
			end
			`CHK("tick_gap", P, sp)
			`CHK("conv_len", 1'h1, d > 14 * P && d <= 15 * P + 2)
			wait_irq(n);
			`CHK("irq_one", 1'h1, irq_flag)
			rd(SAR_BUF_OFF);
			`CHK("result_fmt", rows[i].x, q)
			rd(SAR_STAT_OFF);
			`CHK("done_bit", 1'h1, q[1])
			off();
		end
		$display("format test done");
		wr(SAR_CTRL2_OFF, 32'h0000041E);
		wr(SAR_CTRL3_OFF, 32'h0000010D);
		wr(SAR_SCAN_OFF, 32'h0000AAB6);
		wr(SAR_CTRL1_OFF, 32'h0000003F);
		for (int h = 0; h < 2; h++) begin
			wait_irq(n);
			if (h == 0) `CHK("half_count", 8, n)
			rd(SAR_STAT_OFF);
			`CHK("half_sel", h == 0, q[2])
			for (int i = 0; i < 8; i++) begin
				rd(SAR_BUF_OFF + 8'(4 * (i + 8 * h)));
				`CHK("scan_word", {20'h00000, 8'hA0, scan_ch[i]}, q)
			end
			wr(SAR_STAT_OFF, 32'h00000000);
		end
		wr(SAR_BUF_OFF + 8'h04, 32'h00000FFF);
		`CHK("buf_wr_err", 1'h1, e)
		rd(SAR_BUF_OFF + 8'h04);
		`CHK("buf_ro", 32'h00000A02, q)
		off();
		$display("split scan test done");
		wr(SAR_CTRL2_OFF, 32'h00000005);
		wr(SAR_INSEL_OFF, 32'h00000093);
		wr(SAR_CTRL1_OFF, 32'h0000003F);
		wait_irq(n);
		rd(SAR_BUF_OFF);
		`CHK("alt_first", 32'h00000A03, q)
		rd(SAR_BUF_OFF + 8'h04);
		`CHK("alt_second", 32'h00000A09, q)
		off();
		$display("alternate test done");
		for (int i = 0; i < 2; i++) begin
			wr(SAR_INSEL_OFF, 32'h00000008 + 2 * i);
			wr(SAR_CTRL1_OFF, i ? 32'h00000011 : 32'h00000009);
			wr(SAR_CTRL1_OFF, i ? 32'h00000013 : 32'h0000000B);
			repeat (30) @(posedge ref_clk);
			`CHK("no_trig", 1'h0, conv_busy)
			if (i) timer_trig <= 1'h1;
			else ext_trig_pin <= 1'h1;
			@(posedge ref_clk);
			timer_trig <= 1'h0;
			repeat (4) @(posedge ref_clk);
			ext_trig_pin <= 1'h0;
			wait_irq(n);
			rd(SAR_BUF_OFF);
			`CHK("trig_word", 32'h00000A08 + 2 * i, q)
			off();
		end
		$display("trigger test done");
		start_sw(2'h0, 4'h7);
		repeat (50) @(posedge ref_clk);
		wr(SAR_CTRL1_OFF, 32'h00000000);
		repeat (2) @(posedge ref_clk);
		`CHK("abort_busy", 1'h0, conv_busy)
		repeat (250) @(posedge ref_clk);
		rd(SAR_BUF_OFF);
		`CHK("abort_keep", 32'h00000A0A, q)
		`CHK("abort_irq", 1'h0, irq_flag)
		repeat (2 * P) @(posedge ref_clk);
		start_sw(2'h0, 4'h7);
		wait_irq(n);
		rd(SAR_BUF_OFF);
		`CHK("after_abort", 32'h00000A07, q)
		off();
		$display("abort test done");
		wr(SAR_CTRL3_OFF, 32'h0000008D);
		wr(SAR_CTRL1_OFF, 32'h00000001);
		lt = 0;
		for (d = 1; d <= 200; d++) begin
			@(posedge ref_clk);
			if (conv_clk_tick === 1'h1) begin
				sp = d - lt;
				lt = d;
			end
		end
		`CHK("rc_tick_gap", 1'h1, sp == 16 || sp == 17)
		off();
		$display("rc clock test done");
		close_out;
	end
endmodule // sar_seq_test
`default_nettype wire

// *** verilog/sar_pkg.sv ***
// sar_pkg: register map, field layout, reset values and timing for the sar sequencer.
// assumes a 32-bit apb master and a reference clock at twice the instruction rate.
`default_nettype none
package sar_pkg;
	localparam logic [7:0] SAR_CTRL1_OFF = 8'h00;
	localparam logic [7:0] SAR_CTRL2_OFF = 8'h04;
	localparam logic [7:0] SAR_CTRL3_OFF = 8'h08;
	localparam logic [7:0] SAR_INSEL_OFF = 8'h0C;
	localparam logic [7:0] SAR_SCAN_OFF = 8'h10;
	localparam logic [7:0] SAR_STAT_OFF = 8'h14;
	localparam logic [7:0] SAR_BUF_OFF = 8'h40;
	localparam int SAR_WORDS = 16;
	localparam int SAR_RES_W = 12;
	localparam logic [3:0] SAR_CONV_TADS = 4'hF;
	localparam logic [3:0] SAR_HALF_LAST = 4'h7;
	localparam logic [2:0] SAR_TRIG_SW = 3'h0;
	localparam logic [2:0] SAR_TRIG_EXT = 3'h1;
	localparam logic [2:0] SAR_TRIG_TMR = 3'h2;
	localparam logic [2:0] SAR_TRIG_AUTO = 3'h7;
	localparam logic [1:0] SAR_FMT_INT = 2'h0;
	localparam logic [1:0] SAR_FMT_SINT = 2'h1;
	localparam logic [1:0] SAR_FMT_FRAC = 2'h2;
	localparam logic [1:0] SAR_FMT_SFRAC = 2'h3;
	localparam logic [15:0] SAR_SCAN_RST = 16'h0000;
	localparam logic [31:0] SAR_ZERO = 32'h0000_0000;

	typedef enum logic [2:0] {
		SAR_IDLE = 3'b001,
		SAR_SAMPLE = 3'b010,
		SAR_CONV = 3'b100
	} sar_state_t;

	// software-visible configuration
	typedef struct packed {
		logic module_on;
		logic auto_sample;
		logic [2:0] trigger_source;
		logic [1:0] output_format;
		logic alternate_input_select;
		logic buffer_split;
		logic [3:0] samples_per_irq;
		logic scan_enable;
		logic [5:0] conv_clock_select;
		logic rc_clock_select;
		logic [4:0] auto_sample_time;
		logic [3:0] first_input_group;
		logic [3:0] second_input_group;
	} sar_cfg_t;

	localparam sar_cfg_t SAR_CFG_RST = '0;
endpackage
`default_nettype wire

// *** verilog/sar_seq.sv ***
// sar_seq: converter sequencer with apb registers and sixteen-word result buffer.
// assumes ref_clk at twice the instruction rate, so one ref_clk cycle is half a tcy;
// the analog core samples while sample_hold is high and presents its result on
// conv_result_pin by the end of the fifteenth conversion clock.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// (R1) setting sample_request with the module on starts acquisition
// (R2) each conversion stores its result; done and irq flag after the programmed count
// (R3) samples_per_irq plus one sequences run before an interrupt, one to sixteen
// (R4) buffer_split makes two eight-word halves, swapped at each interrupt
// (R5) split with samples_per_irq 0111 fills eight words per half
// (R6) alternate input clear: every sample uses the first input group
// (R7) alternate input set: first and second group used on alternate sequences
// (R8) scan_enable steps first group through inputs set in scan_select_reg
// (R9) scan runs low to high, restarts after each interrupt, extras unused
// (R10) trigger 000: software clearing sample_request starts conversion
// (R11) trigger 111: conversion starts after auto_sample_time conversion clocks
// (R12) software keeps auto_sample_time at one clock or more in auto mode
// (R13) timer and external events can also trigger, chosen by trigger_source
// (R14) clearing module_on aborts conversion without writing the buffer
// (R15) disable wins over a coinciding auto start
// (R16) software waits two conversion clocks after abort before sampling again
// (R17) a conversion lasts fifteen conversion clock periods
// (R18) conversion clock period is half tcy times conv_clock_select plus one
// (R19) rc_clock_select uses the rc oscillator and ignores conv_clock_select
// (R20) software keeps conversion clock period at 667 ns or longer
// (R21) software leaves sequencing settings alone while module is on
// (R22) result buffer holds sixteen 12-bit words, read only
// (R23) output_format gives integer, signed, fractional or signed fractional reads; code 11 reads the same as fractional, zero-filled and not signed
// (R24) results fill consecutive positions, restarting at buffer or half start
module sar_seq (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer_trig,
	input wire logic ext_trig_pin,
	input wire logic rc_osc_pin,
	input wire logic [sar_pkg::SAR_RES_W-1:0] conv_result_pin,
	output logic sample_hold,
	output logic conv_busy,
	output logic conv_clk_tick,
	output logic [3:0] mux_channel,
	output logic irq_flag
);
	import sar_pkg::*;

	sar_cfg_t cfg;
	sar_state_t st;
	logic sample_request, converter_irq_flag, done, half, use_second;
	logic [3:0] seq_cnt, conv_cnt, wr_idx, scan_ch, next_chan;
	logic [4:0] sample_request_cnt;
	logic [5:0] div_cnt;
	logic [15:0] scan_select_reg, scan_used;
	logic [SAR_RES_W-1:0] result_buffer [SAR_WORDS];
	logic [2:0] ext_sync, rc_sync;
	logic [SAR_RES_W-1:0] res_s1, res_s2, rd_word;
	logic tad_tick, trig, complete, last_seq, wr_en, clr_irq, setup, scan_any, next_err;
	logic [31:0] next_rdata;

	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite;

	// pins from outside pass two flops before use
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ext_sync <= 3'h0;
			rc_sync <= 3'h0;
			res_s1 <= '0;
			res_s2 <= '0;
		end else begin
			ext_sync <= {ext_sync[1:0], ext_trig_pin};
			rc_sync <= {rc_sync[1:0], rc_osc_pin};
			res_s1 <= conv_result_pin;
			res_s2 <= res_s1;
		end
	end

	// conversion clock: a one-cycle enable, never a derived clock
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !cfg.module_on || cfg.rc_clock_select) begin
			div_cnt <= 6'h00;
		end else if (div_cnt == cfg.conv_clock_select) begin
			div_cnt <= 6'h00; // (R18)
		end else begin
			div_cnt <= div_cnt + 6'h01;
		end
	end
	assign tad_tick = cfg.module_on && (cfg.rc_clock_select ? (rc_sync[1] && !rc_sync[2]) // (R19)
		: (div_cnt == cfg.conv_clock_select)); // (R18)

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			conv_clk_tick <= 1'b0;
		end else begin
			conv_clk_tick <= tad_tick;
		end
	end

	always_comb begin
		unique case (cfg.trigger_source)
			SAR_TRIG_SW: trig = !sample_request; // (R10)
			SAR_TRIG_EXT: trig = ext_sync[1] && !ext_sync[2]; // (R13)
			SAR_TRIG_TMR: trig = timer_trig; // (R13)
			SAR_TRIG_AUTO: trig = tad_tick && (sample_request_cnt + 5'h01 >= cfg.auto_sample_time); // (R11)
			default: trig = 1'b0;
		endcase
	end

	assign complete = (st == SAR_CONV) && cfg.module_on && tad_tick && (conv_cnt == SAR_CONV_TADS - 4'h1);
	assign last_seq = seq_cnt == cfg.samples_per_irq; // (R3)
	assign wr_idx = cfg.buffer_split ? {half, seq_cnt[2:0]} : seq_cnt; // (R4) (R24)

	// sequencer; module_on is tested first so disable beats any start
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st <= SAR_IDLE;
			conv_cnt <= 4'h0;
			sample_request_cnt <= 5'h00;
		end else if (!cfg.module_on) begin
			st <= SAR_IDLE; // (R14) (R15)
			conv_cnt <= 4'h0;
			sample_request_cnt <= 5'h00;
		end else begin
			unique case (st)
				SAR_IDLE: begin
					sample_request_cnt <= 5'h00;
					if (sample_request) begin
						st <= SAR_SAMPLE; // (R1)
					end
				end
				SAR_SAMPLE: begin
					if (trig) begin
						st <= SAR_CONV;
						conv_cnt <= 4'h0;
					end else if (tad_tick) begin
						sample_request_cnt <= sample_request_cnt + 5'h01; // (R11)
					end
				end
				SAR_CONV: begin
					if (complete) begin
						st <= SAR_IDLE; // (R17)
					end else if (tad_tick) begin
						conv_cnt <= conv_cnt + 4'h1; // (R17)
					end
				end
			endcase
		end
	end

	// result store: only a finished conversion writes, so abort keeps old words
	always_ff @(posedge ref_clk) begin
		if (complete) begin
			result_buffer[wr_idx] <= res_s2; // (R2) (R14) (R22)
		end
	end

	// sequence position, half select, alternation and scan bookkeeping
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			seq_cnt <= 4'h0;
			half <= 1'b0;
			use_second <= 1'b0;
			scan_used <= 16'h0000;
		end else if (complete) begin
			if (last_seq) begin
				seq_cnt <= 4'h0; // (R24)
				use_second <= 1'b0;
				scan_used <= 16'h0000; // (R9)
				if (cfg.buffer_split) begin
					half <= !half; // (R4) (R5)
				end
			end else begin
				seq_cnt <= seq_cnt + 4'h1;
				use_second <= cfg.alternate_input_select && !use_second; // (R7)
				if (!use_second && cfg.scan_enable && scan_any) begin
					scan_used[scan_ch] <= 1'b1; // (R8)
				end
			end
		end
	end

	// lowest selected input not yet converted since the last interrupt
	always_comb begin
		scan_ch = 4'h0;
		scan_any = 1'b0;
		for (int i = SAR_WORDS - 1; i >= 0; i--) begin
			if (scan_select_reg[i] && !scan_used[i]) begin
				scan_ch = 4'(i); // (R9)
				scan_any = 1'b1;
			end
		end
		if (use_second && cfg.alternate_input_select) begin
			next_chan = cfg.second_input_group; // (R7)
		end else if (cfg.scan_enable) begin
			next_chan = scan_ch; // (R8)
		end else begin
			next_chan = cfg.first_input_group; // (R6)
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mux_channel <= 4'h0;
			sample_hold <= 1'b0;
			conv_busy <= 1'b0;
		end else begin
			mux_channel <= next_chan;
			sample_hold <= cfg.module_on && (st == SAR_SAMPLE) && !trig;
			conv_busy <= cfg.module_on && ((st == SAR_CONV && !complete) || (st == SAR_SAMPLE && trig));
		end
	end

	// flags: hardware set wins over a software clear in the same cycle
	assign clr_irq = wr_en && paddr[7:0] == SAR_STAT_OFF && !pwdata[0];
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			converter_irq_flag <= 1'b0;
			done <= 1'b0;
			irq_flag <= 1'b0;
		end else begin
			if (complete && last_seq) begin
				converter_irq_flag <= 1'b1; // (R2)
				done <= 1'b1; // (R2)
			end else begin
				if (clr_irq) begin
					converter_irq_flag <= 1'b0;
				end
				if (st == SAR_IDLE && sample_request && cfg.module_on) begin
					done <= 1'b0;
				end
			end
			irq_flag <= converter_irq_flag;
		end
	end

	// configuration registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cfg <= SAR_CFG_RST;
			scan_select_reg <= SAR_SCAN_RST;
		end else if (wr_en) begin
			unique case (paddr[7:0])
				SAR_CTRL1_OFF: begin
					cfg.module_on <= pwdata[0];
					cfg.auto_sample <= pwdata[2];
					cfg.trigger_source <= pwdata[5:3];
					cfg.output_format <= pwdata[7:6];
				end
				SAR_CTRL2_OFF: begin
					cfg.alternate_input_select <= pwdata[0];
					cfg.buffer_split <= pwdata[1];
					cfg.samples_per_irq <= pwdata[5:2];
					cfg.scan_enable <= pwdata[10];
				end
				SAR_CTRL3_OFF: begin
					cfg.conv_clock_select <= pwdata[5:0];
					cfg.rc_clock_select <= pwdata[7];
					cfg.auto_sample_time <= pwdata[12:8];
				end
				SAR_INSEL_OFF: begin
					cfg.first_input_group <= pwdata[3:0];
					cfg.second_input_group <= pwdata[7:4];
				end
				SAR_SCAN_OFF: scan_select_reg <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// sample_request: software bit, cleared by hardware triggers, re-armed by auto_sample
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sample_request <= 1'b0;
		end else if (complete && cfg.auto_sample) begin
			sample_request <= 1'b1;
		end else if (st == SAR_SAMPLE && trig && cfg.trigger_source != SAR_TRIG_SW) begin
			sample_request <= 1'b0;
		end else if (wr_en && paddr[7:0] == SAR_CTRL1_OFF) begin
			sample_request <= pwdata[1]; // (R1) (R10)
		end
	end

	// read mux; buffer words formatted at read time
	always_comb begin
		rd_word = result_buffer[paddr[5:2]];
		next_err = 1'b0;
		next_rdata = SAR_ZERO;
		if (paddr[7:6] == SAR_BUF_OFF[7:6] && paddr[1:0] == 2'h0) begin
			unique case (cfg.output_format)
				SAR_FMT_INT: next_rdata = {20'h00000, rd_word}; // (R23)
				SAR_FMT_SINT: next_rdata = {{20{rd_word[11]}}, rd_word}; // (R23)
				SAR_FMT_FRAC: next_rdata = {16'h0000, rd_word, 4'h0}; // (R23)
				SAR_FMT_SFRAC: next_rdata = {16'h0000, rd_word, 4'h0}; // (R23)
			endcase
			next_err = pwrite; // (R22)
		end else begin
			unique case (paddr[7:0])
				SAR_CTRL1_OFF: next_rdata = {24'h000000, cfg.output_format, cfg.trigger_source,
					cfg.auto_sample, sample_request, cfg.module_on};
				SAR_CTRL2_OFF: next_rdata = {21'h00000, cfg.scan_enable, 4'h0, cfg.samples_per_irq,
					cfg.buffer_split, cfg.alternate_input_select};
				SAR_CTRL3_OFF: next_rdata = {19'h0000, cfg.auto_sample_time, cfg.rc_clock_select,
					1'b0, cfg.conv_clock_select};
				SAR_INSEL_OFF: next_rdata = {24'h000000, cfg.second_input_group, cfg.first_input_group};
				SAR_SCAN_OFF: next_rdata = {16'h0000, scan_select_reg};
				SAR_STAT_OFF: next_rdata = {28'h0000000, conv_busy, half, done, converter_irq_flag};
				default: next_err = 1'b1;
			endcase
		end
	end

	// one wait-free access cycle: data and status captured at setup
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			prdata <= SAR_ZERO;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? SAR_ZERO : next_rdata;
				pslverr <= next_err;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_disable_stops_seq: assert property (!cfg.module_on |=> st == SAR_IDLE && !conv_busy) // (R14)
		else $error("sequencer ran with module off");
	a_auto_start_ok: assert property (st == SAR_SAMPLE && cfg.module_on && trig // (R11)
		&& cfg.trigger_source == SAR_TRIG_AUTO |=> st == SAR_CONV ##1 conv_busy)
		else $error("auto start did not begin conversion");
	a_auto_vs_off: assert property (st == SAR_SAMPLE && !cfg.module_on |=> st == SAR_IDLE && !conv_busy) // (R15)
		else $error("conversion began despite disable");
	a_conv_len_end: assert property (complete |=> st == SAR_IDLE && $past(conv_cnt) == 4'hE) // (R17)
		else $error("conversion length wrong");
	a_irq_on_count: assert property (complete && last_seq |=> converter_irq_flag && done ##1 irq_flag) // (R2)
		else $error("flags not set at programmed count");
	a_seq_advance: assert property (complete && !last_seq |=> seq_cnt == $past(seq_cnt) + 4'h1) // (R3)
		else $error("sequence count did not advance");
	a_half_swap_irq: assert property (complete && last_seq && cfg.buffer_split |=> half != $past(half)) // (R4)
		else $error("buffer half not swapped");
	a_first_group: assert property (!cfg.alternate_input_select && !cfg.scan_enable // (R6)
		|=> mux_channel == $past(cfg.first_input_group))
		else $error("channel not from first group");
	a_alt_second: assert property (use_second && cfg.alternate_input_select // (R7)
		|=> mux_channel == $past(cfg.second_input_group))
		else $error("second group not used");
	a_scan_restart: assert property (complete && last_seq |=> scan_used == 16'h0000) // (R9)
		else $error("scan did not restart");
endmodule // sar_seq
`default_nettype wire
